// [flash_program_download_control_test.sv]
// Self-checking bench for the flash program download control block
`timescale 1ns/1ps
module flash_program_download_control_test;
//----------------------------------------------------------------
// Ports and bench state
//----------------------------------------------------------------
reg         i_ref_clk, i_reset, i_boot_mode, hold, i_download_request_bit;
reg         i_program_select_bit, i_erase_select_bit, i_ram_emulation;
reg         i_fetch_from_ram, i_target_valid, i_init_request, i_op_request;
reg         i_op_boot_array, i_foreign_master, i_nmi;
reg  [7:0]  i_flash_unlock_key, i_cpu_frequency_param, bcnt, cd_sr, r;
reg  [31:0] i_download_target_address;
wire        i_rx_valid, o_rx_ready, o_tx_valid, o_erase_all, o_prog_valid;
wire        o_erase_valid, o_read_enable, o_download_request_bit;
wire        o_map_program_area, o_copy_start, o_clear_selects, o_irq_block;
wire        o_target_address_error_bit, o_user_prog_enable, o_nmi_pending;
wire        o_error_protect;
wire [7:0]  i_rx_data, o_tx_data, o_prog_data, o_erase_block;
wire [7:0]  o_download_result_param, o_operation_result_param;
wire [31:0] o_prog_addr, o_init_entry;
wire        i_flash_busy = hold | (|bcnt);
wire        i_copy_done = cd_sr[7];
integer     n_mismatch, num_checks, n_tx, n_ea, n_pg, n_er, n_cp, n_cl, k, j;
fpdc_top dut_u (.*);
fpdc_host host_u (.i_ref_clk(i_ref_clk), .i_rx_ready(o_rx_ready),
	.o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));
initial begin
	i_ref_clk = 1'b0;
	forever #12.5 i_ref_clk = ~i_ref_clk;
end
//----------------------------------------------------------------
// Checking and closing
//----------------------------------------------------------------
task chk(input [31:0] seen, input [31:0] exp); begin
	num_checks = num_checks + 1;
	if (seen !== exp) begin
		n_mismatch = n_mismatch + 1;
		$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
	end
end endtask
task conclude; begin
	$display("checks %0d mismatches %0d", num_checks, n_mismatch);
	if (n_mismatch == 0 && num_checks > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
end endtask
// Pulse the request, then wait a bounded time for map and request to drop
task dl_go; begin
	@(posedge i_ref_clk) i_download_request_bit <= 1'b1;
	@(posedge i_ref_clk) i_download_request_bit <= 1'b0;
	repeat (3) @(negedge i_ref_clk);
	k = 0;
	while ((o_download_request_bit !== 1'b0 || o_map_program_area !== 1'b0)
		&& k < 40) begin
		@(negedge i_ref_clk);
		k = k + 1;
	end
	chk(k < 40, 1);
end endtask
task pulse_op(input is_init); begin
	@(posedge i_ref_clk);
	if (is_init) i_init_request <= 1'b1; else i_op_request <= 1'b1;
	@(posedge i_ref_clk);
	{i_init_request, i_op_request} <= 2'b00;
	repeat (3) @(negedge i_ref_clk);
end endtask
//----------------------------------------------------------------
// Flash array and RAM copier stand-ins, output monitors
//----------------------------------------------------------------
always @(posedge i_ref_clk) begin
	if (!i_reset) begin
		if (o_tx_valid) chk(o_tx_data, 8'h00);
		n_tx = n_tx + o_tx_valid;
		n_ea = n_ea + o_erase_all;
		if (o_prog_valid) begin
			chk(o_prog_addr, 32'h100 + n_pg);
			chk(o_prog_data, n_pg % 128 < 100 ? n_pg % 128 : 8'hff);
			n_pg = n_pg + 1;
		end
		if (o_erase_valid) chk(o_erase_block, n_er ? 8'h05 : 8'h03);
		n_er = n_er + o_erase_valid;
		n_cp = n_cp + o_copy_start;
		n_cl = n_cl + o_clear_selects;
		bcnt <= o_erase_all ? 8'd20 : (bcnt != 0 ? bcnt - 8'd1 : 8'd0);
		cd_sr <= {cd_sr[6:0], o_copy_start};
	end else begin
		bcnt <= 8'd0;
		cd_sr <= 8'd0;
	end
end
initial begin
	repeat (20000) @(posedge i_ref_clk);
	n_mismatch = n_mismatch + 1;
	conclude;
end
//----------------------------------------------------------------
// Tests
//----------------------------------------------------------------
initial begin
	{hold, i_download_request_bit, i_program_select_bit, i_erase_select_bit,
		i_ram_emulation, i_init_request, i_op_request, i_op_boot_array,
		i_foreign_master, i_nmi, i_flash_unlock_key} = 0;
	{n_mismatch, num_checks, n_tx, n_ea, n_pg, n_er, n_cp, n_cl} = 0;
	{i_reset, i_boot_mode, i_fetch_from_ram, i_target_valid} = 4'hf;
	i_cpu_frequency_param = 8'h10;
	i_download_target_address = 32'h00002000;
	repeat (12) @(posedge i_ref_clk);
	i_reset <= 1'b0;
	@(negedge i_ref_clk);
	chk(o_download_result_param, 8'hff);
	chk(o_read_enable, 0);
	$display("test reset: end");
	host_u.boot_in;
	k = 0;
	while (o_read_enable !== 1'b1 && k < 200) begin
		@(negedge i_ref_clk);
		k = k + 1;
	end
	chk(o_read_enable, 1);
	chk(n_tx, 1);
	chk(n_ea, 1);
	$display("test boot entry: end");
	@(posedge i_ref_clk) hold <= 1'b1;
	fork
		begin
			host_u.send(8'h43);
			host_u.unit(32'h100, 100);
			host_u.unit(32'h180, 100);
			host_u.unit(32'hffffffff, 0);
		end
		begin
			repeat (150) @(negedge i_ref_clk);
			chk(o_rx_ready, 0);
			@(posedge i_ref_clk) hold <= 1'b0;
		end
	join
	repeat (100) @(negedge i_ref_clk);
	chk(n_pg, 256);
	host_u.send(8'h48);
	host_u.send(8'h03);
	host_u.send(8'h05);
	host_u.send(8'hff);
	repeat (40) @(negedge i_ref_clk);
	chk(n_er, 2);
	$display("test boot program and erase: end");
	@(posedge i_ref_clk) i_boot_mode <= 1'b0;
	i_program_select_bit <= 1'b1;
	for (j = 0; j < 3; j = j + 1) begin
		@(posedge i_ref_clk);
		i_flash_unlock_key <= j == 0 ? 8'h00 : 8'ha5;
		i_ram_emulation <= j == 1;
		i_fetch_from_ram <= j != 2;
		dl_go;
		chk(n_cp, 0);
		chk(o_download_result_param, 8'hff);
	end
	@(posedge i_ref_clk) i_fetch_from_ram <= 1'b1;
	fork
		dl_go;
		begin
			repeat (5) @(negedge i_ref_clk);
			chk(o_irq_block, 1);
			@(posedge i_ref_clk) i_nmi <= 1'b1;
			@(posedge i_ref_clk) i_nmi <= 1'b0;
			@(negedge i_ref_clk) chk(o_nmi_pending, 1);
		end
	join
	chk(o_download_result_param, 8'h00);
	chk(n_cl, 1);
	@(negedge i_ref_clk);
	chk(o_nmi_pending, 0);
	@(posedge i_ref_clk) i_erase_select_bit <= 1'b1;
	dl_go;
	chk(o_download_result_param[1], 1);
	chk(o_download_result_param[2], 0);
	chk(n_cp, 1);
	@(posedge i_ref_clk) i_erase_select_bit <= 1'b0;
	i_target_valid <= 1'b0;
	r = o_download_result_param;
	dl_go;
	chk(o_target_address_error_bit, 1);
	chk(o_download_result_param, r);
	@(posedge i_ref_clk) i_flash_unlock_key <= 8'h00;
	$display("test download: end");
	for (j = 0; j < 4; j = j + 1) begin
		@(posedge i_ref_clk);
		i_cpu_frequency_param <= j == 0 ? 8'h09 : j == 1 ? 8'h0a :
			j == 2 ? 8'h1a : 8'h1b;
		pulse_op(1'b1);
		chk(o_operation_result_param,
			j == 0 || j == 3 ? 8'h01 : 8'h00);
	end
	chk(o_init_entry, 32'h00002020);
	for (j = 0; j < 3; j = j + 1) begin
		@(posedge i_ref_clk);
		i_flash_unlock_key <= j == 1 ? 8'h00 : 8'h5a;
		i_op_boot_array <= j == 0;
		pulse_op(1'b0);
		if (j < 2)
			chk(o_operation_result_param, j == 0 ? 8'h02 : 8'h04);
		else
			chk(o_user_prog_enable, 1);
	end
	@(posedge i_ref_clk) hold <= 1'b1;
	repeat (6) @(negedge i_ref_clk);
	chk(o_error_protect, 0);
	@(posedge i_ref_clk) i_foreign_master <= 1'b1;
	pulse_op(1'b0);
	@(posedge i_ref_clk) i_foreign_master <= 1'b0;
	i_flash_unlock_key <= 8'h00;
	repeat (3) @(negedge i_ref_clk);
	chk(o_error_protect, 1);
	$display("test user mode: end");
	@(posedge i_ref_clk) {hold, i_reset} <= 2'b11;
	repeat (4000) @(posedge i_ref_clk);
	{hold, i_reset} <= 2'b00;
	@(negedge i_ref_clk);
	chk(o_error_protect, 0);
	chk(o_download_result_param, 8'hff);
	chk(o_read_enable, 0);
	$display("test reset in flight: end");
	conclude;
end
endmodule

// [fpdc_chk_asserts.sv]
// Port-level checker for the flash program download control block
`timescale 1ns/1ps
module fpdc_chk (
	// Clock and reset
	input wire       i_ref_clk,
	input wire       i_reset,
	// Watched inputs
	input wire [7:0] i_flash_unlock_key,
	input wire       i_ram_emulation,
	input wire       i_fetch_from_ram,
	input wire       i_foreign_master,
	// Watched outputs
	input wire       o_download_request_bit,
	input wire       o_copy_start,
	input wire       o_map_program_area,
	input wire       o_user_prog_enable,
	input wire       o_erase_valid,
	input wire [7:0] o_erase_block,
	input wire       o_prog_valid,
	input wire       o_read_enable,
	input wire       o_error_protect,
	input wire       o_target_address_error_bit,
	input wire [7:0] o_download_result_param
);
default clocking @(posedge i_ref_clk); endclocking
default disable iff (i_reset);
AST_DL_GATE: assert property ($rose(o_download_request_bit) |->
	$past(i_flash_unlock_key) == 8'ha5 && !$past(i_ram_emulation) &&
	$past(i_fetch_from_ram)) else $error("download began while locked");
AST_DL_SHORT: assert property (o_download_request_bit |->
	##[1:40] !o_download_request_bit) else $error("request bit stuck");
AST_COPY_MAP: assert property (o_copy_start |->
	o_map_program_area && o_download_request_bit)
	else $error("copy outside mapped download");
AST_PROG_KEY: assert property (o_user_prog_enable |->
	$past(i_flash_unlock_key) == 8'h5a) else $error("enable without key");
AST_ERASE_END: assert property (o_erase_valid |->
	o_erase_block != 8'hff) else $error("end marker used as a block");
AST_ERASE_FIRST: assert property (o_prog_valid || o_erase_valid |->
	o_read_enable) else $error("array work before automatic erase");
AST_PROT_CAUSE: assert property ($rose(o_error_protect) |->
	$past(i_foreign_master) || $past(i_foreign_master, 2))
	else $error("protect without foreign master");
AST_PROT_HOLD: assert property (o_error_protect |=> o_error_protect)
	else $error("protect state released");
AST_TARGET_ADDRESS_ERROR_BIT_KEEP: assert property ($rose(o_target_address_error_bit) |->
	$stable(o_download_result_param)) else $error("result changed on bad target");
endmodule
bind fpdc_top fpdc_chk chk_u (.*);

// [fpdc_fifo.v]
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module fpdc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire             i_ref_clk,
	input  wire             i_reset,
	// Fill side
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_in_ready,
	// Drain side
	output wire             o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wr_r;
	reg [AW-1:0]    rd_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;

	assign o_in_ready  = (cnt_r != DEPTH[AW:0]);
	assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
	assign o_out_data  = mem_r[rd_r];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			wr_r  <= {AW{1'b0}};
			rd_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_r[wr_r] <= i_in_data;
				wr_r        <= (wr_r == DEPTH[AW-1:0] - 1'b1) ?
				               {AW{1'b0}} : wr_r + 1'b1;
			end
			if (pop)
				rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ?
				        {AW{1'b0}} : rd_r + 1'b1;
			if (push & ~pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// [fpdc_host.sv]
// Host programming tool model feeding the boot byte stream
`timescale 1ns/1ps
module fpdc_host (
	// Clock
	input  wire       i_ref_clk,
	// Byte stream toward the block
	input  wire       i_rx_ready,
	output reg        o_rx_valid,
	output reg  [7:0] o_rx_data
);
integer i;
initial begin
	o_rx_valid = 1'b0;
	o_rx_data = 8'h00;
end
// Holds a byte until an edge samples ready, then shows its inverse
task send(input [7:0] b); begin
	@(posedge i_ref_clk);
	o_rx_valid <= 1'b1;
	o_rx_data <= b;
	do @(posedge i_ref_clk); while (i_rx_ready !== 1'b1);
	o_rx_valid <= 1'b0;
	o_rx_data <= ~b;
end endtask
task boot_in; begin
	send(8'h00);
	send(8'h55);
	send(8'h01);
end endtask
// Address MSB first; an all-ones address ends programming
task unit(input [31:0] a, input [7:0] n); begin
	for (i = 3; i >= 0; i = i - 1) send(a[i*8 +: 8]);
	if (a != 32'hffffffff)
		for (i = 0; i < 128; i = i + 1) send(i < n ? i[7:0] : 8'hff);
end endtask
endmodule

// [fpdc_regs.vh]
// Constants for the flash program download control block
`ifndef FPDC_REGS_VH
`define FPDC_REGS_VH
`define FPDC_KEY_DL       8'ha5
`define FPDC_KEY_PROG     8'h5a
`define FPDC_KEY_CLEAR    8'h00
`define FPDC_PROG_END     32'hffffffff
`define FPDC_ERASE_END    8'hff
`define FPDC_BIT_SYNC     8'h00
`define FPDC_BIT_CONFIRM  8'h55
`define FPDC_CMD_PROG     8'h43
`define FPDC_CMD_ERASE    8'h48
`define FPDC_CMD_READ     8'h52
`define FPDC_UNIT_BYTES   8'h80
`define FPDC_UNIT_CNT_W   7
`define FPDC_BUSY_SETTLE  7'h08
`define FPDC_RES_OK       8'h00
`define FPDC_RES_SS_BIT   1
`define FPDC_RES_FK_BIT   2
`define FPDC_TARGET_ADDRESS_ERROR_BIT_BIT     7
`define FPDC_INIT_OFS     32'h00000020
`define FPDC_ERR_FREQ     8'h01
`define FPDC_ERR_BOOT_MAT 8'h02
`define FPDC_ERR_PROTECT  8'h04
`define FPDC_ERR_ADDR     8'h08
`define FPDC_FIFO_DEPTH   32
`define FPDC_FIFO_AW      5
`endif

// [fpdc_top.v]
// Flash program download control: boot command flow and user download
//------------------------------------------------------------------------
//------------------------------------------------------------------------
`timescale 1ns/1ps
`include "fpdc_regs.vh"
module fpdc_top #(
	parameter [7:0] FREQ_MIN = 8'h0a,
	parameter [7:0] FREQ_MAX = 8'h1a
) (
	// Clock and reset
	input  wire        i_ref_clk,
	input  wire        i_reset,
	// Mode and serial byte stream from the link receiver
	input  wire        i_boot_mode,
	input  wire        i_rx_valid,
	input  wire [7:0]  i_rx_data,
	output reg         o_rx_ready,
	output reg         o_tx_valid,
	output reg  [7:0]  o_tx_data,
	// Flash array operation requests
	output reg         o_erase_all,
	output reg         o_prog_valid,
	output reg  [31:0] o_prog_addr,
	output reg  [7:0]  o_prog_data,
	output reg         o_erase_valid,
	output reg  [7:0]  o_erase_block,
	input  wire        i_flash_busy,
	output reg         o_read_enable,
	// User program mode controls
	input  wire [7:0]  i_flash_unlock_key,
	input  wire        i_download_request_bit,
	input  wire        i_program_select_bit,
	input  wire        i_erase_select_bit,
	input  wire        i_ram_emulation,
	input  wire        i_fetch_from_ram,
	input  wire [31:0] i_download_target_address,
	input  wire        i_target_valid,
	input  wire        i_copy_done,
	input  wire [7:0]  i_cpu_frequency_param,
	input  wire        i_init_request,
	input  wire        i_op_request,
	input  wire        i_op_boot_array,
	input  wire        i_foreign_master,
	input  wire        i_nmi,
	// User program mode status
	output reg         o_download_request_bit,
	output reg         o_map_program_area,
	output reg         o_copy_start,
	output reg         o_clear_selects,
	output reg  [7:0]  o_download_result_param,
	output reg         o_target_address_error_bit,
	output reg  [31:0] o_init_entry,
	output reg  [7:0]  o_operation_result_param,
	output reg         o_user_prog_enable,
	output reg         o_irq_block,
	output reg         o_nmi_pending,
	output reg         o_error_protect
);
	localparam S_SYNC = 4'h0, S_CONF = 4'h1, S_INQ = 4'h2, S_ERA = 4'h3;
	localparam S_CMD = 4'h4, S_PADR = 4'h5, S_PDAT = 4'h6, S_EBLK = 4'h7;
	localparam D_IDLE = 3'h0, D_MAP = 3'h1, D_CHK = 3'h2, D_COPY = 3'h3;
	localparam D_CLR = 3'h4, D_RES = 3'h5, D_UNMAP = 3'h6;

	reg  [3:0]  bst_r;
	reg  [1:0]  abyte_r;
	reg  [31:0] addr_r;
	reg  [`FPDC_UNIT_CNT_W-1:0] cnt_r;
	reg  [2:0]  dst_r;
	reg  [7:0]  res_r;
	reg         erased_r;
	reg         busy_s1_r;
	reg         busy_s2_r;
	reg         busy_s3_r;
	reg         busy_f_r;
	wire        f_valid;
	wire [7:0]  f_data;
	wire        f_ready;
	wire        f_in_ready;
	wire        key_dl;
	wire        key_pg;
	wire        sel_err;

	// Registered ready idles a cycle after each byte so none is ever lost
	fpdc_fifo #(
		.WIDTH (8),
		.DEPTH (`FPDC_FIFO_DEPTH),
		.AW    (`FPDC_FIFO_AW)
	) u_fifo (
		.i_ref_clk   (i_ref_clk),
		.i_reset     (i_reset),
		.i_in_valid  (i_rx_valid & o_rx_ready),
		.i_in_data   (i_rx_data),
		.o_in_ready  (f_in_ready),
		.o_out_valid (f_valid),
		.o_out_data  (f_data),
		.i_out_ready (f_ready)
	);

	assign key_dl  = (i_flash_unlock_key == `FPDC_KEY_DL);
	assign key_pg  = (i_flash_unlock_key == `FPDC_KEY_PROG);
	assign sel_err = i_program_select_bit & i_erase_select_bit;
	assign f_ready = i_boot_mode & ~busy_f_r & ~o_prog_valid &
	                 ~o_erase_valid & ~o_tx_valid &
	                 (bst_r != S_ERA);

	//--------------------------------------------------------------------
	// Boot mode command flow
	//--------------------------------------------------------------------
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			bst_r         <= S_SYNC;
			abyte_r       <= 2'h0;
			addr_r        <= 32'h00000000;
			cnt_r         <= {`FPDC_UNIT_CNT_W{1'b0}};
			erased_r      <= 1'b0;
			busy_s1_r     <= 1'b0;
			busy_s2_r     <= 1'b0;
			busy_s3_r     <= 1'b0;
			busy_f_r      <= 1'b0;
			o_rx_ready    <= 1'b0;
			o_tx_valid    <= 1'b0;
			o_tx_data     <= 8'h00;
			o_erase_all   <= 1'b0;
			o_prog_valid  <= 1'b0;
			o_prog_addr   <= 32'h00000000;
			o_prog_data   <= 8'h00;
			o_erase_valid <= 1'b0;
			o_erase_block <= 8'h00;
			o_read_enable <= 1'b0;
		end else begin
			busy_s1_r     <= i_flash_busy;
			busy_s2_r     <= busy_s1_r;
			busy_s3_r     <= busy_s2_r;
			busy_f_r <= (busy_s2_r == busy_s3_r) ? busy_s2_r : busy_f_r;
			o_rx_ready    <= f_in_ready & ~(i_rx_valid & o_rx_ready);
			o_tx_valid    <= 1'b0;
			o_erase_all   <= 1'b0;
			o_prog_valid  <= 1'b0;
			o_erase_valid <= 1'b0;
			o_read_enable <= erased_r;
			case (bst_r)
			S_SYNC: begin
				if (f_valid & f_ready & (f_data == `FPDC_BIT_SYNC)) begin
					o_tx_valid <= 1'b1;
					o_tx_data  <= `FPDC_BIT_SYNC;
					bst_r      <= S_CONF;
				end
			end
			S_CONF: begin
				if (f_valid & f_ready & (f_data == `FPDC_BIT_CONFIRM))
					bst_r <= S_INQ;
			end
			S_INQ: begin
				if (f_valid & f_ready & (f_data != `FPDC_BIT_CONFIRM)) begin
					o_erase_all <= 1'b1;
					bst_r       <= S_ERA;
				end
			end
			S_ERA: begin
				if (cnt_r != `FPDC_BUSY_SETTLE)
					cnt_r <= cnt_r + 1'b1;
				else if (~busy_f_r) begin
					erased_r <= 1'b1;
					bst_r    <= S_CMD;
				end
			end
			S_CMD: begin
				if (f_valid & f_ready) begin
					abyte_r <= 2'h0;
					if (f_data == `FPDC_CMD_PROG)
						bst_r <= S_PADR;
					else if (f_data == `FPDC_CMD_ERASE)
						bst_r <= S_EBLK;
				end
			end
			S_PADR: begin
				if (f_valid & f_ready) begin
					addr_r  <= {addr_r[23:0], f_data};
					abyte_r <= abyte_r + 2'h1;
					if (abyte_r == 2'h3) begin
						if ({addr_r[23:0], f_data} == `FPDC_PROG_END)
							bst_r <= S_CMD;
						else begin
							cnt_r <= {`FPDC_UNIT_CNT_W{1'b0}};
							bst_r <= S_PDAT;
						end
					end
				end
			end
			S_PDAT: begin
				if (f_valid & f_ready) begin
					o_prog_valid <= 1'b1;
					o_prog_addr  <= addr_r + {25'h0, cnt_r};
					o_prog_data  <= f_data;
					cnt_r        <= cnt_r + 1'b1;
					if (cnt_r == `FPDC_UNIT_BYTES - 8'h01) begin
						addr_r  <= addr_r + {24'h0, `FPDC_UNIT_BYTES};
						abyte_r <= 2'h0;
						bst_r   <= S_PADR;
					end
				end
			end
			S_EBLK: begin
				if (f_valid & f_ready) begin
					if (f_data == `FPDC_ERASE_END)
						bst_r <= S_CMD;
					else begin
						o_erase_valid <= 1'b1;
						o_erase_block <= f_data;
					end
				end
			end
			default: bst_r <= S_SYNC;
			endcase
		end
	end

	//--------------------------------------------------------------------
	// User program mode download sequence
	//--------------------------------------------------------------------
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			dst_r                      <= D_IDLE;
			res_r                      <= 8'h00;
			o_download_request_bit     <= 1'b0;
			o_map_program_area         <= 1'b0;
			o_copy_start               <= 1'b0;
			o_clear_selects            <= 1'b0;
			o_download_result_param    <= 8'hff;
			o_target_address_error_bit <= 1'b0;
			o_init_entry               <= 32'h00000000;
			o_operation_result_param   <= 8'h00;
			o_user_prog_enable         <= 1'b0;
			o_irq_block                <= 1'b0;
			o_nmi_pending              <= 1'b0;
			o_error_protect            <= 1'b0;
		end else begin
			o_copy_start       <= 1'b0;
			o_clear_selects    <= 1'b0;
			o_user_prog_enable <= key_pg & ~i_boot_mode;
			// Release in D_IDLE wins; an NMI arriving there is not latched
			if (i_nmi & (dst_r != D_IDLE))
				o_nmi_pending <= 1'b1;
			else if (dst_r == D_IDLE)
				o_nmi_pending <= 1'b0;
			if (i_foreign_master & (busy_f_r | o_prog_valid |
			    o_erase_valid))
				o_error_protect <= 1'b1;
			if (i_init_request) begin
				o_init_entry <= i_download_target_address +
				                `FPDC_INIT_OFS;
				if ((i_cpu_frequency_param < FREQ_MIN) |
				    (i_cpu_frequency_param > FREQ_MAX))
					o_operation_result_param <= `FPDC_ERR_FREQ;
				else
					o_operation_result_param <= `FPDC_RES_OK;
			end else if (i_op_request) begin
				if (i_op_boot_array)
					o_operation_result_param <= `FPDC_ERR_BOOT_MAT;
				else if (~key_pg)
					o_operation_result_param <= `FPDC_ERR_PROTECT;
				else
					o_operation_result_param <= `FPDC_RES_OK;
			end
			case (dst_r)
			D_IDLE: begin
				o_irq_block <= 1'b0;
				if (i_download_request_bit & key_dl & ~i_ram_emulation &
				    i_fetch_from_ram) begin
					o_download_request_bit <= 1'b1;
					o_irq_block            <= 1'b1;
					dst_r                  <= D_MAP;
				end
			end
			D_MAP: begin
				o_map_program_area <= 1'b1;
				dst_r              <= D_CHK;
			end
			D_CHK: begin
				res_r <= `FPDC_RES_OK;
				o_target_address_error_bit <= ~i_target_valid;
				if (~i_target_valid)
					dst_r <= D_CLR;
				else if (sel_err) begin
					res_r[`FPDC_RES_SS_BIT] <= 1'b1;
					dst_r <= D_CLR;
				end else if (~key_dl) begin
					res_r[`FPDC_RES_FK_BIT] <= 1'b1;
					dst_r <= D_CLR;
				end else begin
					o_copy_start <= 1'b1;
					dst_r        <= D_COPY;
				end
			end
			D_COPY: begin
				if (i_copy_done)
					dst_r <= D_CLR;
			end
			D_CLR: begin
				o_clear_selects        <= 1'b1;
				o_download_request_bit <= 1'b0;
				dst_r                  <= D_RES;
			end
			D_RES: begin
				if (~o_target_address_error_bit)
					o_download_result_param <= res_r;
				dst_r <= D_UNMAP;
			end
			D_UNMAP: begin
				o_map_program_area <= 1'b0;
				dst_r              <= D_IDLE;
			end
			default: dst_r <= D_IDLE;
			endcase
		end
	end
endmodule
